// [logic/sfc_check.sv]
// Store buffer with store-to-load forward decision and dependence predictor.
// Assumes the pipeline presents only loads younger than every buffered store,
// and that it retries a stalled load itself.
`timescale 1ns/1ps

// How it works
// - A wide load covering several narrower stores is not forwarded; it stalls.
// - Byte loads at non-start offsets of an aligned wider store stall until written.
// - Aligned 16/32-bit stores forward only the documented aligned load cases.
// - Aligned 64/128-bit stores forward size-aligned 32/64/128-bit loads and 8/16-bit at start.
// - Unaligned store at byte 1 forwards 8/16/32-bit loads at its start only.
// - Unaligned store at byte 7 forwards 8-bit loads only, any offset.
// - A forwarding load waits until its store data has arrived.
// - Predict dependent loads; an unheld load that could forward from late store data takes a penalty.
// - Stores go to memory only after retirement; until then they may forward.
// - Forward only when one store holds every byte the load needs.
// - Unrelated loads proceed, passing blocked loads; one whose tag is predicted dependent waits while any store lacks data.
module sfc_check #(
    parameter int DEPTH     = sfc_pkg::DEPTH,
    parameter int PRED_BITS = sfc_pkg::PRED_BITS
) (
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        arst_n,
    // Pipeline flush of unretired stores
    input  wire logic                        flush,
    // Store allocation
    input  wire logic                        st_alloc_valid,
    input  wire sfc_pkg::sfc_acc_type        st_alloc,
    output logic                             st_alloc_ready,
    output logic [$clog2(DEPTH)-1:0]         st_alloc_idx,
    // Store data arrival
    input  wire logic                        st_data_valid,
    input  wire logic [$clog2(DEPTH)-1:0]    st_data_idx,
    input  wire logic [sfc_pkg::DATA_W-1:0]  st_data,
    // Store retirement
    input  wire logic                        st_retire,
    // Memory write port
    output logic                             mem_wr_valid,
    output sfc_pkg::sfc_acc_type             mem_wr,
    output logic [sfc_pkg::DATA_W-1:0]       mem_wr_data,
    input  wire logic                        mem_wr_ready,
    // Load check
    input  wire logic                        ld_valid,
    input  wire sfc_pkg::sfc_acc_type        ld,
    input  wire logic [PRED_BITS-1:0]        ld_tag,
    output sfc_pkg::sfc_res_type             ld_res,
    output logic [sfc_pkg::DATA_W-1:0]       ld_data,
    output logic                             ld_penalty,
    output logic                             ld_pred_wait
);

    localparam int IW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || PRED_BITS < 1) begin : g_bad_depth
        $error("DEPTH must be a power of two, at least 2, and PRED_BITS at least 1");
    end

    // ------------------------------------------------------------
    // Forward legality for a contained load
    // ------------------------------------------------------------
    function automatic logic fwd_ok(input logic [3:0] sa, input logic [2:0] ssz,
                                    input logic [3:0] off, input logic [2:0] lsz);
        logic [3:0] smask;
        logic       ok;
        smask = 4'(((5'h1 << ssz) - 5'h1));
        ok    = 1'b0;
        if ((sa & smask) == 4'h0) begin
            case (ssz)
                sfc_pkg::SZ_8:  ok = 1'b1;
                sfc_pkg::SZ_16: ok = (off[0] == 1'b0);
                sfc_pkg::SZ_32: ok = (lsz == sfc_pkg::SZ_16) ? (off[0] == 1'b0) : (off == 4'h0);
                default: begin
                    // Size-aligned 32/64-bit loads anywhere, others only at the start.
                    if (lsz == sfc_pkg::SZ_32) begin
                        ok = (off[1:0] == 2'h0);
                    end else if (lsz == sfc_pkg::SZ_64) begin
                        ok = (off[2:0] == 3'h0);
                    end else begin
                        ok = (off == 4'h0);
                    end
                end
            endcase
        end else if (sa[2:0] == sfc_pkg::LATE_START_BYTE) begin
            ok = (lsz == sfc_pkg::SZ_8);
        end else begin
            ok = (off == 4'h0) && (lsz <= sfc_pkg::SZ_32);
        end
        return ok;
    endfunction

    // ------------------------------------------------------------
    // Store buffer state
    // ------------------------------------------------------------
    sfc_pkg::sfc_acc_type           acc_r  [DEPTH];
    logic [sfc_pkg::DATA_W-1:0]     data_r [DEPTH];
    logic [DEPTH-1:0]               drdy_r;
    logic [IW-1:0]                  head_r;
    logic [IW-1:0]                  tail_r;
    logic [CW-1:0]                  cnt_r;
    logic [CW-1:0]                  ret_cnt_r;
    logic [(1<<PRED_BITS)-1:0]      pred_r;

    wire logic            push = st_alloc_valid && st_alloc_ready && !flush;
    wire logic            pop  = mem_wr_valid && mem_wr_ready;
    wire logic            ret  = st_retire && !flush && (ret_cnt_r < cnt_r);
    wire logic [CW-1:0]   ret_cnt_nxt = ret_cnt_r + CW'(ret) - CW'(pop);
    wire logic [IW-1:0]   head_nxt    = head_r + IW'(pop);
    wire logic [CW-1:0]   cnt_nxt     = flush ? ret_cnt_nxt : cnt_r + CW'(push) - CW'(pop);
    wire logic [IW-1:0]   tail_nxt    = flush ? head_nxt + IW'(ret_cnt_nxt) : tail_r + IW'(push);

    // Only retired stores with their data reach memory, oldest first.
    assign st_alloc_ready = (cnt_r != CW'(DEPTH));
    assign st_alloc_idx   = tail_r;
    assign mem_wr_valid   = (ret_cnt_r != CW'(0)) && drdy_r[head_r];
    assign mem_wr         = acc_r[head_r];
    assign mem_wr_data    = data_r[head_r];

    // Pointer and count update; a flush drops only the unretired tail.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            head_r    <= '0;
            tail_r    <= '0;
            cnt_r     <= '0;
            ret_cnt_r <= '0;
        end else begin
            head_r    <= head_nxt;
            tail_r    <= tail_nxt;
            cnt_r     <= cnt_nxt;
            ret_cnt_r <= ret_cnt_nxt;
        end
    end

    // Entry contents; data arrival is written after allocation so it wins.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            drdy_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                acc_r[i]  <= '0;
                data_r[i] <= '0;
            end
        end else begin
            if (push) begin
                acc_r[tail_r]  <= st_alloc;
                drdy_r[tail_r] <= 1'b0;
            end
            if (st_data_valid) begin
                data_r[st_data_idx] <= st_data;
                drdy_r[st_data_idx] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Overlap per entry
    // ------------------------------------------------------------
    logic [DEPTH-1:0] live_w;
    logic [DEPTH-1:0] ov_w;
    wire logic [sfc_pkg::ADDR_W:0] ld_lo = {1'b0, ld.addr};
    wire logic [sfc_pkg::ADDR_W:0] ld_hi = ld_lo + ((sfc_pkg::ADDR_W+1)'(1) << ld.size);

    for (genvar g = 0; g < DEPTH; g++) begin : g_ov
        wire logic [IW-1:0]            age  = IW'(g) - head_r;
        wire logic [sfc_pkg::ADDR_W:0] s_lo = {1'b0, acc_r[g].addr};
        wire logic [sfc_pkg::ADDR_W:0] s_hi = s_lo + ((sfc_pkg::ADDR_W+1)'(1) << acc_r[g].size);
        assign live_w[g] = (CW'(age) < cnt_r);
        assign ov_w[g]   = live_w[g] && (ld_lo < s_hi) && (s_lo < ld_hi);
    end

    // Youngest overlapping store: scanning oldest to youngest, the last hit stays.
    logic          hit_w;
    logic [IW-1:0] sel_w;
    always_comb begin
        logic [IW-1:0] idx;
        idx   = '0;
        hit_w = 1'b0;
        sel_w = '0;
        for (int k = 0; k < DEPTH; k++) begin
            idx = head_r + IW'(k);
            if (ov_w[idx]) begin
                hit_w = 1'b1;
                sel_w = idx;
            end
        end
    end

    // ------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------
    wire sfc_pkg::sfc_acc_type     sel_acc  = acc_r[sel_w];
    wire logic [sfc_pkg::ADDR_W:0] sel_lo   = {1'b0, sel_acc.addr};
    wire logic [sfc_pkg::ADDR_W:0] sel_hi   = sel_lo + ((sfc_pkg::ADDR_W+1)'(1) << sel_acc.size);
    wire logic                     contain  = (ld_lo >= sel_lo) && (ld_hi <= sel_hi);
    wire logic [3:0]               off_w    = 4'(ld.addr - sel_acc.addr);
    wire logic                     legal_w  = contain && fwd_ok(sel_acc.addr[3:0], sel_acc.size, off_w, ld.size);
    wire logic                     late_w   = !drdy_r[sel_w];
    wire logic                     any_late = |(live_w & ~drdy_r);
    // A predicted-dependent load holds while any buffered store lacks data; cheaper than a late hit.
    wire logic                     hold_w   = pred_r[ld_tag] && any_late;
    wire logic [sfc_pkg::DATA_W-1:0] fwd_data_w = data_r[sel_w] >> {off_w, 3'h0};

    logic res_fwd;
    logic res_stall;
    assign res_fwd   = hit_w && legal_w && !late_w && !hold_w;
    assign res_stall = hit_w ? !res_fwd : hold_w;
    assign ld_pred_wait = ld_valid && hold_w;

    // Registered answer, data and predictor training.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ld_res     <= sfc_pkg::SFC_RES_IDLE;
            ld_data    <= '0;
            ld_penalty <= 1'b0;
            pred_r     <= '0;
        end else begin
            ld_penalty <= ld_valid && hit_w && legal_w && late_w && !hold_w;
            ld_data    <= (ld_valid && res_fwd) ? fwd_data_w : '0;
            if (!ld_valid) begin
                ld_res <= sfc_pkg::SFC_RES_IDLE;
            end else if (res_fwd) begin
                ld_res <= sfc_pkg::SFC_RES_FWD;
            end else if (res_stall) begin
                ld_res <= sfc_pkg::SFC_RES_STALL;
            end else begin
                ld_res <= sfc_pkg::SFC_RES_CACHE;
            end
            if (ld_valid && hit_w && legal_w && late_w) begin
                pred_r[ld_tag] <= 1'b1;
            end else if (ld_valid && !hit_w && !hold_w) begin
                pred_r[ld_tag] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_LATE_DATA_STALLS: assert property (
        ld_valid && hit_w && late_w |=> ld_res == sfc_pkg::SFC_RES_STALL)
        else $error("Load forwarded from a store whose data is missing");
    AST_SPLIT_STALLS: assert property (
        ld_valid && hit_w && !contain |=> ld_res == sfc_pkg::SFC_RES_STALL)
        else $error("Load not contained in one store was not stalled");
    AST_ILLEGAL_STALLS: assert property (
        ld_valid && hit_w && !legal_w |=> ld_res == sfc_pkg::SFC_RES_STALL)
        else $error("Misaligned forward case was not stalled");
    AST_FREE_LOAD_GOES: assert property (
        ld_valid && !hit_w && !hold_w |=> ld_res == sfc_pkg::SFC_RES_CACHE)
        else $error("Unrelated load was held");
    AST_FWD_DATA: assert property (
        ld_valid && res_fwd |=> ld_res == sfc_pkg::SFC_RES_FWD && ld_data == $past(fwd_data_w))
        else $error("Forwarded data does not match the youngest store");
    AST_WRITE_RETIRED: assert property (
        mem_wr_valid |-> ret_cnt_r != CW'(0) && drdy_r[head_r])
        else $error("Unretired store sent to memory");
    AST_WRITE_HOLDS: assert property (
        mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && mem_wr == $past(mem_wr))
        else $error("Waiting memory write dropped or changed before acceptance");
    AST_FLUSH_KEEPS_RETIRED: assert property (
        flush |=> cnt_r == ret_cnt_r)
        else $error("Flush left unretired stores or lost retired ones");
    AST_PENALTY_TRAINS: assert property (
        ld_penalty |-> ld_res == sfc_pkg::SFC_RES_STALL && pred_r[$past(ld_tag)])
        else $error("Penalty without stall or without predictor training");
    AST_IDLE: assert property (
        !ld_valid |=> ld_res == sfc_pkg::SFC_RES_IDLE && !ld_penalty)
        else $error("Answer given without a load");

endmodule

// [logic/sfc_pkg.sv]
// Shared constants and types for the store-to-load forward check.
// Assumes a byte-addressed core with store widths of 8 to 128 bits.
package sfc_pkg;

    // ------------------------------------------------------------
    // Widths and defaults
    // ------------------------------------------------------------
    localparam int ADDR_W    = 32;
    localparam int DATA_W    = 128;
    localparam int DEPTH     = 4;
    localparam int PRED_BITS = 4;

    // ------------------------------------------------------------
    // Access size codes, log2 of the byte count
    // ------------------------------------------------------------
    localparam logic [2:0] SZ_8   = 3'h0;
    localparam logic [2:0] SZ_16  = 3'h1;
    localparam logic [2:0] SZ_32  = 3'h2;
    localparam logic [2:0] SZ_64  = 3'h3;
    localparam logic [2:0] SZ_128 = 3'h4;

    // Byte position in a qword at which an unaligned store forwards bytes only.
    localparam logic [2:0] LATE_START_BYTE = 3'h7;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [2:0]        size;
    } sfc_acc_type;

    typedef enum logic [3:0] {
        SFC_RES_IDLE  = 4'h1,
        SFC_RES_CACHE = 4'h2,
        SFC_RES_FWD   = 4'h4,
        SFC_RES_STALL = 4'h8
    } sfc_res_type;

endpackage

// [verif/sfc_mem_model.sv]
// Memory side model for the store buffer write port.
// Assumes one clock and an active-low asynchronous reset shared with the buffer.
`timescale 1ns/1ps

module sfc_mem_model (
    // Clock and reset
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    // Write port
    input  wire logic                 slow,
    input  wire logic                 mem_wr_valid,
    input  wire sfc_pkg::sfc_acc_type mem_wr,
    output logic                      mem_wr_ready,
    // Observation for the bench
    output int                        wr_count,
    output logic [31:0]               last_addr
);
    logic [1:0] wait_r;

    // A slow memory holds off each write for three cycles, so the buffer head must wait.
    assign mem_wr_ready = !slow || (wait_r == 2'h3);

    // Count accepted writes and keep the last address.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wait_r    <= 2'h0;
            wr_count  <= 0;
            last_addr <= 32'h0;
        end else if (mem_wr_valid && mem_wr_ready) begin
            wait_r    <= 2'h0;
            wr_count  <= wr_count + 1;
            last_addr <= mem_wr.addr;
        end else if (mem_wr_valid) begin
            wait_r    <= wait_r + 2'h1;
        end
    end
endmodule

// [verif/store_load_forward_check_test.sv]
// Self-checking bench for the store-to-load forward check.
// Assumes the design package is compiled first and the memory model beside it.
`timescale 1ns/1ps

module store_load_forward_check_test;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 clock = 0, arst_n = 0, flush = 0, slow = 0;
    logic                 st_alloc_valid = 0, st_data_valid = 0, st_retire = 0, ld_valid = 0;
    sfc_pkg::sfc_acc_type st_alloc = '0, ld = '0, mem_wr;
    logic [1:0]           st_data_idx = '0, st_alloc_idx, idx;
    logic [127:0]         st_data = '0, mem_wr_data, ld_data;
    logic [3:0]           ld_tag = '0;
    logic                 st_alloc_ready, mem_wr_valid, mem_wr_ready, ld_penalty, ld_pred_wait;
    sfc_pkg::sfc_res_type ld_res;
    logic [31:0]          last_addr;
    logic [7:0]           salt = 8'h11;
    logic                 exp_wait = 1'b0;
    int                   wr_count, bad_count = 0, total_checks = 0;

    // A 25 ns period gives the 40 MHz core clock.
    always #12.5 clock = ~clock;

    sfc_check #(.DEPTH(4), .PRED_BITS(4)) DUT (.clock(clock), .arst_n(arst_n), .flush(flush),
        .st_alloc_valid(st_alloc_valid), .st_alloc(st_alloc), .st_alloc_ready(st_alloc_ready),
        .st_alloc_idx(st_alloc_idx), .st_data_valid(st_data_valid), .st_data_idx(st_data_idx),
        .st_data(st_data), .st_retire(st_retire), .mem_wr_valid(mem_wr_valid), .mem_wr(mem_wr),
        .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready), .ld_valid(ld_valid), .ld(ld),
        .ld_tag(ld_tag), .ld_res(ld_res), .ld_data(ld_data), .ld_penalty(ld_penalty),
        .ld_pred_wait(ld_pred_wait));

    sfc_mem_model mem (.clock(clock), .arst_n(arst_n), .slow(slow), .mem_wr_valid(mem_wr_valid),
        .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready), .wr_count(wr_count), .last_addr(last_addr));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Byte i of a store is its low address byte plus i plus a salt, so a shifted forward shows.
    function automatic logic [127:0] pat(input logic [31:0] a);
        for (int i = 0; i < 16; i++) pat[i*8 +: 8] = a[7:0] + i[7:0] + salt;
    endfunction

    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // The index is read at the falling edge so it is settled before the allocating edge.
    task automatic put_store(input logic [31:0] a, input logic [2:0] sz, input logic with_data);
        @(negedge clock) idx = st_alloc_idx;
        @(posedge clock) begin
            st_alloc_valid <= 1'b1;
            st_alloc       <= '{addr: a, size: sz};
        end
        @(posedge clock) begin
            st_alloc_valid <= 1'b0;
            st_data_valid  <= with_data;
            st_data_idx    <= idx;
            st_data        <= pat(a);
        end
        @(posedge clock) st_data_valid <= 1'b0;
    endtask

    task automatic do_load(input logic [31:0] a, input logic [2:0] sz, input logic [3:0] tg,
                           input sfc_pkg::sfc_res_type exp);
        @(posedge clock) begin
            ld_valid <= 1'b1;
            ld       <= '{addr: a, size: sz};
            ld_tag   <= tg;
        end
        // The predictor hold is combinational, so it is looked at while the load is presented.
        @(negedge clock) check("ld_pred_wait", ld_pred_wait, exp_wait);
        @(posedge clock) ld_valid <= 1'b0;
        @(negedge clock) check("ld_res", ld_res, exp);
        if (exp == sfc_pkg::SFC_RES_FWD) check("ld_data", ld_data[7:0], 8'(a[7:0] + salt));
    endtask

    // Flush drops every unretired store so each case starts from an empty buffer.
    task automatic clean();
        @(posedge clock) flush <= 1'b1;
        @(posedge clock) flush <= 1'b0;
    endtask

    task automatic run_case(input logic [31:0] sa, input logic [2:0] ssz, input logic [31:0] la,
                            input logic [2:0] lsz, input sfc_pkg::sfc_res_type exp);
        put_store(sa, ssz, 1'b1);
        do_load(la, lsz, 4'h0, exp);
        clean();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_table();
        run_case(32'h100, sfc_pkg::SZ_16, 32'h100, sfc_pkg::SZ_8, sfc_pkg::SFC_RES_FWD);
        run_case(32'h100, sfc_pkg::SZ_16, 32'h101, sfc_pkg::SZ_8, sfc_pkg::SFC_RES_STALL);
        run_case(32'h100, sfc_pkg::SZ_32, 32'h102, sfc_pkg::SZ_16, sfc_pkg::SFC_RES_FWD);
        run_case(32'h100, sfc_pkg::SZ_32, 32'h102, sfc_pkg::SZ_8, sfc_pkg::SFC_RES_STALL);
        run_case(32'h100, sfc_pkg::SZ_64, 32'h104, sfc_pkg::SZ_32, sfc_pkg::SFC_RES_FWD);
        run_case(32'h100, sfc_pkg::SZ_64, 32'h102, sfc_pkg::SZ_16, sfc_pkg::SFC_RES_STALL);
        run_case(32'h100, sfc_pkg::SZ_128, 32'h108, sfc_pkg::SZ_64, sfc_pkg::SFC_RES_FWD);
        run_case(32'h100, sfc_pkg::SZ_128, 32'h10f, sfc_pkg::SZ_8, sfc_pkg::SFC_RES_STALL);
        run_case(32'h101, sfc_pkg::SZ_32, 32'h101, sfc_pkg::SZ_32, sfc_pkg::SFC_RES_FWD);
        run_case(32'h101, sfc_pkg::SZ_64, 32'h101, sfc_pkg::SZ_64, sfc_pkg::SFC_RES_STALL);
        run_case(32'h107, sfc_pkg::SZ_32, 32'h109, sfc_pkg::SZ_8, sfc_pkg::SFC_RES_FWD);
        run_case(32'h107, sfc_pkg::SZ_32, 32'h107, sfc_pkg::SZ_16, sfc_pkg::SFC_RES_STALL);
        run_case(32'h100, sfc_pkg::SZ_32, 32'h102, sfc_pkg::SZ_32, sfc_pkg::SFC_RES_STALL);
        run_case(32'h100, sfc_pkg::SZ_32, 32'h104, sfc_pkg::SZ_8, sfc_pkg::SFC_RES_CACHE);
        $display("test decision table done");
    endtask

    task automatic t_multi();
        put_store(32'h200, sfc_pkg::SZ_8, 1'b1);
        put_store(32'h201, sfc_pkg::SZ_8, 1'b1);
        do_load(32'h200, sfc_pkg::SZ_16, 4'h0, sfc_pkg::SFC_RES_STALL);
        clean();
        put_store(32'h300, sfc_pkg::SZ_32, 1'b1);
        salt = 8'h80;
        put_store(32'h301, sfc_pkg::SZ_8, 1'b1);
        do_load(32'h301, sfc_pkg::SZ_8, 4'h0, sfc_pkg::SFC_RES_FWD);
        clean();
        $display("test several stores done");
    endtask

    task automatic t_late();
        salt = 8'h40;
        put_store(32'h500, sfc_pkg::SZ_32, 1'b0);
        do_load(32'h500, sfc_pkg::SZ_32, 4'h4, sfc_pkg::SFC_RES_STALL);
        check("ld_penalty", ld_penalty, 1'b1);
        do_load(32'h900, sfc_pkg::SZ_32, 4'h5, sfc_pkg::SFC_RES_CACHE);
        // The tag is now trained, so the predictor holds the load while the data is missing.
        exp_wait = 1'b1;
        do_load(32'h500, sfc_pkg::SZ_32, 4'h4, sfc_pkg::SFC_RES_STALL);
        exp_wait = 1'b0;
        check("ld_penalty", ld_penalty, 1'b0);
        @(posedge clock) begin
            st_data_valid <= 1'b1;
            st_data_idx   <= idx;
            st_data       <= pat(32'h500);
        end
        @(posedge clock) st_data_valid <= 1'b0;
        do_load(32'h500, sfc_pkg::SZ_32, 4'h4, sfc_pkg::SFC_RES_FWD);
        clean();
        $display("test late data done");
    endtask

    // The memory stalls each write, so the retired head must hold its request.
    task automatic t_retire();
        slow <= 1'b1;
        put_store(32'h400, sfc_pkg::SZ_32, 1'b1);
        repeat (3) @(negedge clock) check("mem_wr_valid", mem_wr_valid, 1'b0);
        @(posedge clock) st_retire <= 1'b1;
        @(posedge clock) st_retire <= 1'b0;
        // The memory is still holding off, so the retired head must be on offer with its data.
        @(negedge clock) check("mem_wr_valid", mem_wr_valid, 1'b1);
        check("mem_wr_data", mem_wr_data, pat(32'h400));
        for (int n = 0; n < 20 && wr_count == 0; n++) @(negedge clock);
        if (wr_count == 0) begin
            bad_count++;
            stop_test();
        end
        check("mem address", last_addr, 32'h400);
        do_load(32'h400, sfc_pkg::SZ_32, 4'h0, sfc_pkg::SFC_RES_CACHE);
        $display("test retire done");
    endtask

    task automatic t_full();
        // One entry short of full must still accept, so an early full flag shows.
        repeat (3) put_store(32'h600, sfc_pkg::SZ_8, 1'b0);
        @(negedge clock) check("st_alloc_ready", st_alloc_ready, 1'b1);
        put_store(32'h600, sfc_pkg::SZ_8, 1'b0);
        @(negedge clock) check("st_alloc_ready", st_alloc_ready, 1'b0);
        clean();
        @(negedge clock) check("st_alloc_ready", st_alloc_ready, 1'b1);
        $display("test full buffer done");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(negedge clock) check("ld_res after reset", ld_res, sfc_pkg::SFC_RES_IDLE);
        t_table();
        t_multi();
        t_late();
        t_retire();
        t_full();
        stop_test();
    end
endmodule
